//--- verilog/cmss_defines.vh
// Constants for the move/shift/multiply/stack execution block
// Assumes inclusion by bare name from verilog/ design files
`ifndef CMSS_DEFINES_VH
`define CMSS_DEFINES_VH
`define CMSS_OP_W         5
`define CMSS_OP_MOV_LIT16 5'h00
`define CMSS_OP_MOV_LIT8  5'h01
`define CMSS_OP_LOAD_OFS  5'h02
`define CMSS_OP_STORE_OFS 5'h03
`define CMSS_OP_PAIR_FROM 5'h04
`define CMSS_OP_PAIR_TO   5'h05
`define CMSS_OP_MULT_SIGNED_SIGNED_OP    5'h06
`define CMSS_OP_MULT_SIGNED_UNSIGNED_OP    5'h07
`define CMSS_OP_MULT_UNSIGNED_SIGNED_OP    5'h08
`define CMSS_OP_MULT_UNSIGNED_UNSIGNED_OP    5'h09
`define CMSS_OP_MULT_SIGNED_UNSIGNED_OP_L5 5'h0A
`define CMSS_OP_MULT_UNSIGNED_UNSIGNED_OP_L5 5'h0B
`define CMSS_OP_SHR_REG   5'h0C
`define CMSS_OP_SHR_L5    5'h0D
`define CMSS_OP_SHR_ONE_F 5'h0E
`define CMSS_OP_SHR_ONE_W 5'h0F
`define CMSS_OP_NEGATE    5'h10
`define CMSS_OP_PUSH      5'h11
`define CMSS_OP_POP       5'h12
`define CMSS_OP_PUSH_D    5'h13
`define CMSS_OP_POP_D     5'h14
`define CMSS_FLG_C        0
`define CMSS_FLG_DC       1
`define CMSS_FLG_N        2
`define CMSS_FLG_OV       3
`define CMSS_FLG_Z        4
`define CMSS_FLAGS_RST    5'h00
`define CMSS_WORK_IDX     4'h0
`define CMSS_SP_IDX       4'hF
`define CMSS_SP_RST       16'h0800
`define CMSS_ST_IDLE      2'h0
`define CMSS_ST_SECOND    2'h1
`endif

//--- verilog/cmss_mult.v
// Combinational 17x17 multiplier with per-operand sign control
// Assumes caller registers the product
`include "cmss_defines.vh"
module cmss_mult (
  input  wire [15:0] op_a,
  input  wire [15:0] op_b,
  input  wire        a_signed,
  input  wire        b_signed,
  output wire [31:0] product
);
  wire signed [16:0] ext_a;
  wire signed [16:0] ext_b;
  wire signed [33:0] full;
  assign ext_a   = {a_signed & op_a[15], op_a};
  assign ext_b   = {b_signed & op_b[15], op_b};
  assign full    = ext_a * ext_b;
  assign product = full[31:0];
endmodule // cmss_mult

//--- verilog/cmss_exec.v
// Execution unit: moves, pair moves, multiplies, right shifts, negate, stack
// Assumes one instruction issued per op_valid; memory answers in same cycle
// Contract
// RL1: Pair-from move: two words, two cycles, flags kept
// RL2: Pair-to move: high to nd+1, low nd
// RL3: Signed-signed multiply into pair, one cycle
// RL4: Other multiply sign forms, one cycle, no flags
// RL5: Multiply by five-bit literal, one cycle
// RL6: Shift by register amount updates N, Z only
// RL7: Shift by literal: one cycle, N, Z only
// RL8: Single shift of memory word: C,N,OV,Z
// RL9: Sixteen-bit literal move, one cycle, no flags
// RL10: Byte literal move, one cycle, no flags
// RL11: Base plus offset load, one cycle
// RL12: Base plus offset store, one cycle
// RL13: Double pop into pair in two cycles
// RL14: Double push of pair in two cycles
// RL15: Single push in one cycle, no flags
// RL16: Single pop in one cycle, no flags
// RL17: Negate inverts plus one; five flags
// RL18: Flagless forms leave flags exactly unchanged
`include "cmss_defines.vh"
module cmss_exec (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        op_valid,
  input  wire [4:0]  op_code,
  input  wire [3:0]  reg_d,
  input  wire [3:0]  reg_s,
  input  wire [3:0]  reg_b,
  input  wire [15:0] lit_val,
  input  wire [15:0] file_addr,
  input  wire [15:0] mem_rdata,
  output reg         busy_r,
  output reg         done_r,
  output reg         mem_re_r,
  output reg         mem_we_r,
  output reg  [15:0] mem_addr_r,
  output reg  [15:0] mem_wdata_r,
  output reg  [4:0]  flags_r,
  output reg  [15:0] result_r
);
  reg  [15:0] regs_r [0:15];
  reg  [1:0]  state_r;
  reg  [4:0]  op_r;
  reg  [3:0]  d_r;
  reg  [3:0]  s_r;
  reg         pend_fwb_r;
  reg  [15:0] pend_val_r;
  reg  [4:0]  pend_flg_r;
  reg         pend_flg_en_r;
  reg  [15:0] mult_a;
  reg  [15:0] mult_b;
  reg         mult_as;
  reg         mult_bs;
  wire [31:0] product;
  wire [15:0] sp;
  wire [15:0] ofs_addr;
  wire [16:0] neg_sum;
  wire [4:0]  neg_lo;
  integer     i;

  function [3:0] nxt_reg;
    input [3:0] r;
    begin
      nxt_reg = r + 4'h1;
    end
  endfunction

  function [4:0] nz_flags;
    input [4:0]  old;
    input [15:0] v;
    begin
      nz_flags = old;
      nz_flags[`CMSS_FLG_N] = v[15];
      nz_flags[`CMSS_FLG_Z] = (v == 16'h0000);
    end
  endfunction

  assign sp       = regs_r[`CMSS_SP_IDX];
  assign ofs_addr = regs_r[reg_b] + {{6{lit_val[9]}}, lit_val[9:0]}; // RL11
  assign neg_sum  = {1'b0, ~mem_rdata} + 17'h0_0001; // RL17
  assign neg_lo   = {1'b0, ~mem_rdata[3:0]} + 5'h01;

  always @* begin
    mult_a  = regs_r[reg_b];
    mult_b  = regs_r[reg_s];
    mult_as = 1'b0;
    mult_bs = 1'b0;
    case (op_code)
      `CMSS_OP_MULT_SIGNED_SIGNED_OP: begin
        mult_as = 1'b1; // RL3
        mult_bs = 1'b1;
      end
      `CMSS_OP_MULT_SIGNED_UNSIGNED_OP: mult_as = 1'b1; // RL4
      `CMSS_OP_MULT_UNSIGNED_SIGNED_OP: mult_bs = 1'b1; // RL4
      `CMSS_OP_MULT_SIGNED_UNSIGNED_OP_L5: begin
        mult_as = 1'b1; // RL5
        mult_b  = {11'h000, lit_val[4:0]};
      end
      `CMSS_OP_MULT_UNSIGNED_UNSIGNED_OP_L5: mult_b = {11'h000, lit_val[4:0]}; // RL5
      default: mult_as = 1'b0;
    endcase
  end

  cmss_mult u_mult (
    .op_a     (mult_a),
    .op_b     (mult_b),
    .a_signed (mult_as),
    .b_signed (mult_bs),
    .product  (product)
  );

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 16; i = i + 1)
        regs_r[i] <= 16'h0000;
      regs_r[`CMSS_SP_IDX] <= `CMSS_SP_RST;
      state_r       <= `CMSS_ST_IDLE;
      op_r          <= 5'h00;
      d_r           <= 4'h0;
      s_r           <= 4'h0;
      busy_r        <= 1'b0;
      done_r        <= 1'b0;
      mem_re_r      <= 1'b0;
      mem_we_r      <= 1'b0;
      mem_addr_r    <= 16'h0000;
      mem_wdata_r   <= 16'h0000;
      flags_r       <= `CMSS_FLAGS_RST;
      result_r      <= 16'h0000;
      pend_fwb_r    <= 1'b0;
      pend_val_r    <= 16'h0000;
      pend_flg_r    <= 5'h00;
      pend_flg_en_r <= 1'b0;
    end else begin
      done_r   <= 1'b0;
      mem_re_r <= 1'b0;
      mem_we_r <= 1'b0;
      case (state_r)
        `CMSS_ST_IDLE: begin
          if (op_valid) begin
            op_r <= op_code;
            d_r  <= reg_d;
            s_r  <= reg_s;
            case (op_code)
              `CMSS_OP_MOV_LIT16: begin
                regs_r[reg_d] <= lit_val; // RL9
                result_r      <= lit_val;
                done_r        <= 1'b1;
              end
              `CMSS_OP_MOV_LIT8: begin
                regs_r[reg_d][7:0] <= lit_val[7:0]; // RL10
                result_r <= {regs_r[reg_d][15:8], lit_val[7:0]};
                done_r   <= 1'b1;
              end
              `CMSS_OP_LOAD_OFS: begin
                mem_re_r      <= 1'b1;
                mem_addr_r    <= ofs_addr;
                regs_r[reg_d] <= mem_rdata; // RL11
                result_r      <= mem_rdata;
                done_r        <= 1'b1;
              end
              `CMSS_OP_STORE_OFS: begin
                mem_we_r    <= 1'b1; // RL12
                mem_addr_r  <= ofs_addr;
                mem_wdata_r <= regs_r[reg_s];
                result_r    <= regs_r[reg_s];
                done_r      <= 1'b1;
              end
              `CMSS_OP_PAIR_FROM: begin
                regs_r[reg_d] <= regs_r[reg_s]; // RL1
                result_r      <= regs_r[reg_s];
                state_r       <= `CMSS_ST_SECOND;
                busy_r        <= 1'b1;
              end
              `CMSS_OP_PAIR_TO: begin
                regs_r[reg_d] <= regs_r[reg_s]; // RL2
                result_r      <= regs_r[reg_s];
                state_r       <= `CMSS_ST_SECOND;
                busy_r        <= 1'b1;
              end
              `CMSS_OP_MULT_SIGNED_SIGNED_OP, `CMSS_OP_MULT_SIGNED_UNSIGNED_OP, `CMSS_OP_MULT_UNSIGNED_SIGNED_OP,
              `CMSS_OP_MULT_UNSIGNED_UNSIGNED_OP, `CMSS_OP_MULT_SIGNED_UNSIGNED_OP_L5,
              `CMSS_OP_MULT_UNSIGNED_UNSIGNED_OP_L5: begin
                regs_r[reg_d]          <= product[15:0]; // RL3
                regs_r[nxt_reg(reg_d)] <= product[31:16];
                result_r               <= product[15:0];
                done_r                 <= 1'b1;
              end
              `CMSS_OP_SHR_REG: begin
                regs_r[reg_d] <= regs_r[reg_b] >> regs_r[reg_s][3:0];
                result_r <= regs_r[reg_b] >> regs_r[reg_s][3:0];
                flags_r  <= nz_flags(flags_r,
                              regs_r[reg_b] >> regs_r[reg_s][3:0]); // RL6
                done_r   <= 1'b1;
              end
              `CMSS_OP_SHR_L5: begin
                regs_r[reg_d] <= regs_r[reg_b] >> lit_val[4:0];
                result_r <= regs_r[reg_b] >> lit_val[4:0];
                flags_r  <= nz_flags(flags_r,
                              regs_r[reg_b] >> lit_val[4:0]); // RL7
                done_r   <= 1'b1;
              end
              `CMSS_OP_SHR_ONE_F, `CMSS_OP_SHR_ONE_W: begin
                mem_re_r   <= 1'b1;
                mem_addr_r <= file_addr;
                result_r   <= {1'b0, mem_rdata[15:1]};
                flags_r    <= {(mem_rdata[15:1] == 15'h0000), 1'b0, 1'b0,
                               flags_r[`CMSS_FLG_DC], mem_rdata[0]}; // RL8
                if (op_code == `CMSS_OP_SHR_ONE_W)
                  regs_r[`CMSS_WORK_IDX] <= {1'b0, mem_rdata[15:1]};
                else begin
                  mem_we_r    <= 1'b1;
                  mem_wdata_r <= {1'b0, mem_rdata[15:1]};
                end
                done_r <= 1'b1;
              end
              `CMSS_OP_NEGATE: begin
                mem_re_r   <= 1'b1;
                mem_addr_r <= file_addr;
                regs_r[reg_d] <= neg_sum[15:0];
                result_r   <= neg_sum[15:0];
                flags_r[`CMSS_FLG_C]  <= neg_sum[16]; // RL17
                flags_r[`CMSS_FLG_DC] <= neg_lo[4];
                flags_r[`CMSS_FLG_N]  <= neg_sum[15];
                flags_r[`CMSS_FLG_OV] <= (mem_rdata == 16'h8000);
                flags_r[`CMSS_FLG_Z]  <= (neg_sum[15:0] == 16'h0000);
                done_r     <= 1'b1;
              end
              `CMSS_OP_PUSH: begin
                mem_we_r    <= 1'b1; // RL15
                mem_addr_r  <= sp;
                mem_wdata_r <= regs_r[reg_s];
                regs_r[`CMSS_SP_IDX] <= sp + 16'h0002;
                result_r    <= regs_r[reg_s];
                done_r      <= 1'b1;
              end
              `CMSS_OP_POP: begin
                mem_re_r      <= 1'b1;
                mem_addr_r    <= sp - 16'h0002;
                regs_r[reg_d] <= mem_rdata; // RL16
                regs_r[`CMSS_SP_IDX] <= sp - 16'h0002;
                result_r      <= mem_rdata;
                done_r        <= 1'b1;
              end
              `CMSS_OP_PUSH_D: begin
                mem_we_r    <= 1'b1; // RL14
                mem_addr_r  <= sp;
                mem_wdata_r <= regs_r[reg_s];
                regs_r[`CMSS_SP_IDX] <= sp + 16'h0002;
                state_r     <= `CMSS_ST_SECOND;
                busy_r      <= 1'b1;
              end
              `CMSS_OP_POP_D: begin
                mem_re_r   <= 1'b1; // RL13
                mem_addr_r <= sp - 16'h0002;
                regs_r[nxt_reg(reg_d)] <= mem_rdata;
                regs_r[`CMSS_SP_IDX]   <= sp - 16'h0002;
                state_r    <= `CMSS_ST_SECOND;
                busy_r     <= 1'b1;
              end
              default: done_r <= 1'b1;
            endcase
          end
        end
        `CMSS_ST_SECOND: begin
          // Second cycle of the two-cycle forms; flags untouched
          state_r <= `CMSS_ST_IDLE; // RL18
          busy_r  <= 1'b0;
          done_r  <= 1'b1;
          case (op_r)
            `CMSS_OP_PAIR_FROM: begin
              regs_r[nxt_reg(d_r)] <= regs_r[nxt_reg(s_r)]; // RL1
              result_r <= regs_r[nxt_reg(s_r)];
            end
            `CMSS_OP_PAIR_TO: begin
              regs_r[nxt_reg(d_r)] <= regs_r[nxt_reg(s_r)]; // RL2
              result_r <= regs_r[nxt_reg(s_r)];
            end
            `CMSS_OP_PUSH_D: begin
              mem_we_r    <= 1'b1; // RL14
              mem_addr_r  <= sp;
              mem_wdata_r <= regs_r[nxt_reg(s_r)];
              regs_r[`CMSS_SP_IDX] <= sp + 16'h0002;
            end
            `CMSS_OP_POP_D: begin
              mem_re_r   <= 1'b1; // RL13
              mem_addr_r <= sp - 16'h0002;
              regs_r[d_r] <= mem_rdata;
              regs_r[`CMSS_SP_IDX] <= sp - 16'h0002;
              result_r   <= mem_rdata;
            end
            default: result_r <= result_r;
          endcase
        end
        default: begin
          state_r <= `CMSS_ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end
endmodule // cmss_exec

//--- test/cmss_exec_sva.sv
// Checker: timing and flag relations of cmss_exec
// Assumes bind onto cmss_exec, single clock domain
`include "cmss_defines.vh"
module cmss_exec_sva (
  input wire        sys_clk,
  input wire        rst_b,
  input wire        op_valid,
  input wire [4:0]  op_code,
  input wire [15:0] lit_val,
  input wire [15:0] mem_rdata,
  input wire        busy_r,
  input wire        done_r,
  input wire        mem_we_r,
  input wire [4:0]  flags_r,
  input wire [15:0] result_r
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  reg  [15:0] rd_r;
  wire        tk   = op_valid && !busy_r;
  wire        two  = op_code == `CMSS_OP_PAIR_FROM ||
                     op_code == `CMSS_OP_PAIR_TO ||
                     op_code == `CMSS_OP_PUSH_D ||
                     op_code == `CMSS_OP_POP_D;
  wire        nofl = op_code <= `CMSS_OP_MULT_UNSIGNED_UNSIGNED_OP_L5 ||
                     op_code == `CMSS_OP_PUSH || op_code == `CMSS_OP_POP;
  wire        sh   = op_code == `CMSS_OP_SHR_REG ||
                     op_code == `CMSS_OP_SHR_L5;
  wire        sh1  = op_code == `CMSS_OP_SHR_ONE_F ||
                     op_code == `CMSS_OP_SHR_ONE_W;
  // Read data seen at the take edge
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rd_r <= 16'h0000;
    else rd_r <= mem_rdata;
  end
  sequence s_two;
    busy_r ##1 (done_r && !busy_r);
  endsequence
  AST_PAIR_TIME: assert property (tk && two |=> s_two)
    else $error("Two-cycle op timing wrong");
  AST_ONE_TIME: assert property (
    tk && !two && op_code <= `CMSS_OP_POP_D |=> done_r && !busy_r)
    else $error("Single-cycle op timing wrong");
  AST_KEEP_ONE: assert property (tk && nofl && !two |=> $stable(flags_r))
    else $error("Flags changed by flagless op");
  AST_KEEP_TWO: assert property (tk && two |=> $stable(flags_r) [*2])
    else $error("Flags changed by two-cycle op");
  AST_SHIFT_NZ: assert property (
    tk && sh |=> flags_r[2] == result_r[15] &&
    flags_r[4] == (result_r == 16'h0000) && $stable({flags_r[3],flags_r[1:0]}))
    else $error("Shift flags wrong");
  AST_SHIFT_ONE: assert property (tk && sh1 |=> result_r == rd_r >> 1 &&
    flags_r[0] == rd_r[0] && !flags_r[2])
    else $error("Single shift wrong");
  AST_NEG_VAL: assert property (tk && op_code == `CMSS_OP_NEGATE |=>
    result_r == ~rd_r + 16'h0001 && flags_r[3] == (rd_r == 16'h8000))
    else $error("Negate wrong");
  AST_LIT16: assert property (tk && op_code == `CMSS_OP_MOV_LIT16 |=>
    result_r == $past(lit_val))
    else $error("Literal move wrong");
  AST_PUSH_WE: assert property (
    tk && op_code == `CMSS_OP_PUSH |=> mem_we_r)
    else $error("Push without write");
endmodule // cmss_exec_sva
bind cmss_exec cmss_exec_sva i_cmss_exec_sva (.sys_clk, .rst_b, .op_valid,
  .op_code, .lit_val, .mem_rdata, .busy_r, .done_r, .mem_we_r, .flags_r,
  .result_r);

//--- test/tb.sv
// Self-checking bench for cmss_exec
// Assumes design and checker compiled first
`include "cmss_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  reg         sys_clk, rst_b, op_valid;
  reg  [4:0]  op_code;
  reg  [3:0]  reg_d, reg_s, reg_b;
  reg  [15:0] lit_val, file_addr, mem_rdata, sp, hi;
  wire        busy_r, done_r, mem_re_r, mem_we_r;
  wire [15:0] mem_addr_r, mem_wdata_r, result_r;
  wire [4:0]  flags_r;
  integer     n_fail, total_checks, i;
  cmss_exec i_cmss_exec (.sys_clk, .rst_b, .op_valid, .op_code, .reg_d,
    .reg_s, .reg_b, .lit_val, .file_addr, .mem_rdata, .busy_r, .done_r,
    .mem_re_r, .mem_we_r, .mem_addr_r, .mem_wdata_r, .flags_r, .result_r);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task end_of_test;
    begin
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One instruction, then wait for completion
  task run(input [4:0] c, input [3:0] d, s, b, input [15:0] l, rd);
    integer k;
    begin
      @(posedge sys_clk);
      #2;
      {op_code, reg_d, reg_s, reg_b, lit_val, mem_rdata} = {c, d, s, b, l, rd};
      op_valid = 1'b1;
      @(posedge sys_clk);
      #2;
      op_valid = 1'b0;
      k = 0;
      while (done_r !== 1'b1 && k < 4) begin
        @(posedge sys_clk);
        #2;
        k = k + 1;
      end
      chk({15'h0000, done_r}, 16'h0001);
    end
  endtask
  // Register readback through a single push
  task peek(input [3:0] r, input [15:0] exp);
    begin
      run(`CMSS_OP_PUSH, 4'h0, r, 4'h0, 16'h0000, 16'h0000);
      chk(mem_wdata_r, exp);
      chk(mem_addr_r, sp);
      sp = sp + 16'h0002;
    end
  endtask
  task t_lit;
    begin
      run(`CMSS_OP_MOV_LIT16, 4'h1, 4'h0, 4'h0, 16'hA5C3, 16'h0000);
      chk(result_r, 16'hA5C3);
      run(`CMSS_OP_MOV_LIT8, 4'h2, 4'h0, 4'h0, 16'h347E, 16'h0000);
      chk({8'h00, result_r[7:0]}, 16'h007E);
      peek(4'h1, 16'hA5C3);
      run(`CMSS_OP_MOV_LIT16, 4'h5, 4'h0, 4'h0, 16'hFFFE, 16'h0000);
      run(`CMSS_OP_MOV_LIT16, 4'h6, 4'h0, 4'h0, 16'h0003, 16'h0000);
      $display("t_lit done");
    end
  endtask
  task t_stack;
    begin
      run(`CMSS_OP_POP, 4'h3, 4'h0, 4'h0, 16'h0000, 16'h1234);
      sp = sp - 16'h0002;
      chk(result_r, 16'h1234);
      chk(mem_addr_r, sp);
      run(`CMSS_OP_PUSH_D, 4'h0, 4'h5, 4'h0, 16'h0000, 16'h0000);
      chk(mem_wdata_r, 16'h0003);
      chk(mem_addr_r, sp + 16'h0002);
      run(`CMSS_OP_POP_D, 4'h7, 4'h0, 4'h0, 16'h0000, 16'h5A5A);
      peek(4'h8, 16'h5A5A);
      $display("t_stack done");
    end
  endtask
  task t_mul;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        hi = (i == 2 || i == 3 || i == 5) ? 16'h0002 : 16'hFFFF;
        run(`CMSS_OP_MULT_SIGNED_SIGNED_OP + i, 4'h8, 4'h6, 4'h5, 16'h0003, 16'h0000);
        peek(4'h8, 16'hFFFA);
        peek(4'h9, hi);
      end
      run(`CMSS_OP_PAIR_FROM, 4'hA, 4'h8, 4'h0, 16'h0000, 16'h0000);
      peek(4'hA, 16'hFFFA);
      peek(4'hB, 16'h0002);
      run(`CMSS_OP_PAIR_TO, 4'hD, 4'hA, 4'h0, 16'h0000, 16'h0000);
      peek(4'hD, 16'hFFFA);
      peek(4'hE, 16'h0002);
      $display("t_mul done");
    end
  endtask
  task t_shift;
    begin
      run(`CMSS_OP_SHR_L5, 4'h7, 4'h0, 4'h5, 16'h0004, 16'h0000);
      chk(result_r, 16'h0FFF);
      run(`CMSS_OP_SHR_L5, 4'h7, 4'h0, 4'h5, 16'h0011, 16'h0000);
      chk(result_r, 16'h0000);
      run(`CMSS_OP_SHR_REG, 4'h7, 4'h6, 4'h5, 16'h0000, 16'h0000);
      chk(result_r, 16'h1FFF);
      run(`CMSS_OP_SHR_L5, 4'h7, 4'h0, 4'h6, 16'h0002, 16'h0000);
      chk({15'h0000, flags_r[4]}, 16'h0001);
      run(`CMSS_OP_SHR_ONE_F, 4'h0, 4'h0, 4'h0, 16'h0000, 16'h8001);
      chk(result_r, 16'h4000);
      chk(mem_addr_r, file_addr);
      chk({15'h0000, mem_we_r}, 16'h0001);
      run(`CMSS_OP_SHR_ONE_W, 4'h0, 4'h0, 4'h0, 16'h0000, 16'h0002);
      chk({15'h0000, flags_r[0]}, 16'h0000);
      peek(`CMSS_WORK_IDX, 16'h0001);
      $display("t_shift done");
    end
  endtask
  task t_neg;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        hi = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0001 : 16'h8000;
        run(`CMSS_OP_NEGATE, 4'h4, 4'h0, 4'h0, 16'h0000, hi);
        chk(result_r, ~hi + 16'h0001);
        chk({11'h000, flags_r},
            (i == 0) ? 16'h0013 : (i == 1) ? 16'h0004 : 16'h000E);
      end
      $display("t_neg done");
    end
  endtask
  task t_ofs;
    begin
      run(`CMSS_OP_STORE_OFS, 4'h0, 4'h1, 4'h6, 16'h03FE, 16'h0000);
      chk(mem_addr_r, 16'h0001);
      chk(mem_wdata_r, 16'hA5C3);
      run(`CMSS_OP_LOAD_OFS, 4'hC, 4'h0, 4'h6, 16'h0002, 16'hBEEF);
      chk(mem_addr_r, 16'h0005);
      chk({15'h0000, mem_re_r}, 16'h0001);
      peek(4'hC, 16'hBEEF);
      $display("t_ofs done");
    end
  endtask
  initial begin
    #200000;
    n_fail = n_fail + 1;
    end_of_test;
  end
  initial begin
    n_fail = 0;
    total_checks = 0;
    sp = `CMSS_SP_RST;
    {op_valid, op_code, reg_d, reg_s, reg_b, lit_val, mem_rdata} = 0;
    file_addr = 16'h0040;
    rst_b = 1'b0;
    repeat (5) @(posedge sys_clk);
    #2;
    rst_b = 1'b1;
    t_lit;
    t_stack;
    t_mul;
    t_shift;
    t_neg;
    t_ofs;
    end_of_test;
  end
endmodule // tb
